/* verilog/cis_pkg.sv */
// constants, types and register map of the instruction execution unit
package cis_pkg;

	// register byte offsets on the wishbone slave
	localparam logic [7:0] ADDR_CMD    = 8'h00;
	localparam logic [7:0] ADDR_ARG    = 8'h04;
	localparam logic [7:0] ADDR_PC     = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_RFSEL  = 8'h10;
	localparam logic [7:0] ADDR_RFDATA = 8'h14;
	localparam logic [7:0] ADDR_MSEL   = 8'h18;
	localparam logic [7:0] ADDR_MDATA  = 8'h1c;
	localparam logic [7:0] ADDR_RESULT = 8'h20;

	// reset values
	localparam logic [21:0] PC_RESET     = 22'h000000;
	localparam logic [7:0]  STATUS_RESET = 8'h00;
	localparam logic [31:0] CMD_RESET    = 32'h0000003f;

	// status register bit positions
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;
	localparam int unsigned FLAG_I = 7;

	// flag update masks
	localparam logic [7:0] MASK_ARITH = 8'h3f;
	localparam logic [7:0] MASK_WORD  = 8'h1f;
	localparam logic [7:0] MASK_LOGIC = 8'h1e;

	// data space layout
	localparam logic [15:0] IO_BASE    = 16'h0020;
	localparam int unsigned PTR_X_LOW  = 26;
	localparam int unsigned REGS       = 32;

	typedef enum logic [5:0] {
		OP_ADD                       = 6'h00,
		OP_ADD_CARRY                 = 6'h01,
		OP_WORD_IMMEDIATE_SUM        = 6'h02,
		OP_SUB                       = 6'h03,
		OP_SUB_IMMEDIATE             = 6'h04,
		OP_SUB_BORROW                = 6'h05,
		OP_IMMEDIATE_BORROW_SUBTRACT = 6'h06,
		OP_WORD_IMMEDIATE_DIFFERENCE = 6'h07,
		OP_AND                       = 6'h08,
		OP_IMMEDIATE_CONJUNCTION     = 6'h09,
		OP_OR                        = 6'h0a,
		OP_IMMEDIATE_DISJUNCTION     = 6'h0b,
		OP_XOR                       = 6'h0c,
		OP_ONES_COMPLEMENT           = 6'h0d,
		OP_TWOS_COMPLEMENT           = 6'h0e,
		OP_SET_BITS                  = 6'h0f,
		OP_CLEAR_BITS                = 6'h10,
		OP_INCREMENT                 = 6'h11,
		OP_DECREMENT                 = 6'h12,
		OP_ZERO_MINUS_TEST           = 6'h13,
		OP_CLEAR_REG                 = 6'h14,
		OP_SET_REG                   = 6'h15,
		OP_RELATIVE_JUMP             = 6'h16,
		OP_POINTER_JUMP              = 6'h17,
		OP_RELATIVE_CALL             = 6'h18,
		OP_POINTER_CALL              = 6'h19,
		OP_EQUAL_SKIP                = 6'h1a,
		OP_COMPARE                   = 6'h1b,
		OP_COMPARE_CARRY             = 6'h1c,
		OP_IMMEDIATE_COMPARE         = 6'h1d,
		OP_REG_BIT_CLEAR_SKIP        = 6'h1e,
		OP_REG_BIT_SET_SKIP          = 6'h1f,
		OP_IO_BIT_CLEAR_SKIP         = 6'h20,
		OP_IO_BIT_SET_SKIP           = 6'h21,
		OP_STATUS_BIT_BRANCH         = 6'h22,
		OP_STATUS_BIT_CLEAR_BRANCH   = 6'h23,
		OP_SIGNED_GE_BRANCH          = 6'h24,
		OP_SIGNED_LT_BRANCH          = 6'h25,
		OP_UNSIGNED_GE_BRANCH        = 6'h26,
		OP_UNSIGNED_LT_BRANCH        = 6'h27,
		OP_IRQ_ON_BRANCH             = 6'h28,
		OP_IRQ_OFF_BRANCH            = 6'h29,
		OP_DIRECT_LOAD               = 6'h2a,
		OP_PTR_LOAD                  = 6'h2b,
		OP_PTR_LOAD_INC              = 6'h2c,
		OP_PTR_LOAD_DEC              = 6'h2d,
		OP_DISPLACED_LOAD            = 6'h2e,
		OP_NONE                      = 6'h3f
	} cis_op_t;

	// command word written to ADDR_CMD
	typedef struct packed {
		logic [3:0] spare;
		logic       longNext;
		logic [2:0] bitSel;
		logic [7:0] imm;
		logic [4:0] rr;
		logic [4:0] rd;
		cis_op_t    op;
	} cis_cmd_t;

	// alu answer: result word and flag vector
	typedef struct packed {
		logic [15:0] res;
		logic [7:0]  flags;
	} cis_alu_t;

endpackage

/* verilog/cis_exec.sv */
// execution unit for arithmetic, branch and load instructions
`timescale 1ns/1ns
module cis_exec #(
	parameter int DMEM_DEPTH = 256
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// classic wishbone slave
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [7:0]  wbAdr,
	input  wire logic [3:0]  wbSel,
	input  wire logic [31:0] wbDatIn,
	output logic             wbAck,
	output logic [31:0]      wbDatOut
);
	localparam int MAW = $clog2(DMEM_DEPTH);

	if (DMEM_DEPTH < 64 || DMEM_DEPTH > 65536 || (1 << MAW) != DMEM_DEPTH)
	begin : g_depth_check
		$error("DMEM_DEPTH must be a power of two from 64 to 65536");
	end

	logic [7:0]        rf [cis_pkg::REGS];
	logic [7:0]        dmem [DMEM_DEPTH];
	logic [21:0]       pc;
	logic [7:0]        status;
	cis_pkg::cis_cmd_t cmd;
	logic [15:0]       arg;
	logic [4:0]        rfSel;
	logic [15:0]       memSel;
	logic [15:0]       lastResult;
	logic              lastTaken;

	function automatic cis_pkg::cis_alu_t add8(input logic [7:0] x, input logic [7:0] y,
		input logic ci);
		cis_pkg::cis_alu_t o;
		logic [7:0]        r;
		r = 8'(x + y + {7'h00, ci});
		o = '0;
		o.res = {8'h00, r};
		o.flags[cis_pkg::FLAG_H] = x[3] & y[3] | y[3] & ~r[3] | ~r[3] & x[3];
		o.flags[cis_pkg::FLAG_V] = x[7] & y[7] & ~r[7] | ~x[7] & ~y[7] & r[7];
		o.flags[cis_pkg::FLAG_C] = x[7] & y[7] | y[7] & ~r[7] | ~r[7] & x[7];
		o.flags[cis_pkg::FLAG_N] = r[7];
		o.flags[cis_pkg::FLAG_Z] = (r == 8'h00);
		o.flags[cis_pkg::FLAG_S] = r[7] ^ o.flags[cis_pkg::FLAG_V];
		return o;
	endfunction

	// zIn chains the zero flag for the carrying variants
	function automatic cis_pkg::cis_alu_t sub8(input logic [7:0] x, input logic [7:0] y,
		input logic ci, input logic zIn);
		cis_pkg::cis_alu_t o;
		logic [7:0]        r;
		r = 8'(x - y - {7'h00, ci});
		o = '0;
		o.res = {8'h00, r};
		o.flags[cis_pkg::FLAG_H] = ~x[3] & y[3] | y[3] & r[3] | r[3] & ~x[3];
		o.flags[cis_pkg::FLAG_V] = x[7] & ~y[7] & ~r[7] | ~x[7] & y[7] & r[7];
		o.flags[cis_pkg::FLAG_C] = ~x[7] & y[7] | y[7] & r[7] | r[7] & ~x[7];
		o.flags[cis_pkg::FLAG_N] = r[7];
		o.flags[cis_pkg::FLAG_Z] = (r == 8'h00) & zIn;
		o.flags[cis_pkg::FLAG_S] = r[7] ^ o.flags[cis_pkg::FLAG_V];
		return o;
	endfunction

	// logical result: overflow cleared
	function automatic cis_pkg::cis_alu_t logic8(input logic [7:0] r);
		cis_pkg::cis_alu_t o;
		o = '0;
		o.res = {8'h00, r};
		o.flags[cis_pkg::FLAG_N] = r[7];
		o.flags[cis_pkg::FLAG_Z] = (r == 8'h00);
		o.flags[cis_pkg::FLAG_S] = r[7];
		return o;
	endfunction

	function automatic cis_pkg::cis_alu_t word16(input logic [15:0] p, input logic [5:0] k,
		input logic isSub);
		cis_pkg::cis_alu_t o;
		logic [15:0]       r;
		r = isSub ? 16'(p - {10'h000, k}) : 16'(p + {10'h000, k});
		o = '0;
		o.res = r;
		o.flags[cis_pkg::FLAG_V] = isSub ? (p[15] & ~r[15]) : (~p[15] & r[15]);
		o.flags[cis_pkg::FLAG_C] = isSub ? (r[15] & ~p[15]) : (~r[15] & p[15]);
		o.flags[cis_pkg::FLAG_N] = r[15];
		o.flags[cis_pkg::FLAG_Z] = (r == 16'h0000);
		o.flags[cis_pkg::FLAG_S] = r[15] ^ o.flags[cis_pkg::FLAG_V];
		return o;
	endfunction

	function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] o;
		for (int i = 0; i < 4; i++)
			o[8 * i +: 8] = sel[i] ? nw[8 * i +: 8] : old[8 * i +: 8];
		return o;
	endfunction

	function automatic logic [7:0] memRead(input logic [15:0] a);
		return dmem[a[MAW-1:0]];
	endfunction

	// bus strobes
	logic access;
	logic wrEdge;
	logic exec;
	assign access = wbCyc & wbStb;
	assign wrEdge = access & wbWe & wbAck;
	assign exec   = wrEdge & (wbAdr == cis_pkg::ADDR_CMD) & wbSel[0];

	// byte-lane merges of the wide registers
	logic [31:0] pcMerged;
	logic [31:0] argMerged;
	logic [31:0] selMerged;
	assign pcMerged  = byteMerge({10'h000, pc}, wbDatIn, wbSel);
	assign argMerged = byteMerge({16'h0000, arg}, wbDatIn, wbSel);
	assign selMerged = byteMerge({16'h0000, memSel}, wbDatIn, wbSel);

	// operands of the command being written
	cis_pkg::cis_cmd_t c;
	logic [7:0]        a;
	logic [7:0]        b;
	logic [4:0]        rdE;
	logic [15:0]       pairVal;
	logic [15:0]       ptrZ;
	logic [21:0]       relOff;
	logic [21:0]       brOff;
	logic [21:0]       skipPc;
	assign c       = cis_pkg::cis_cmd_t'(wbDatIn);
	assign a       = rf[c.rd];
	assign b       = rf[c.rr];
	assign rdE     = {c.rd[4:1], 1'b0};
	assign pairVal = {rf[5'(rdE | 5'd1)], rf[rdE]};
	assign ptrZ    = {rf[31], rf[30]};
	assign relOff  = {{10{arg[11]}}, arg[11:0]};
	assign brOff   = {{15{arg[6]}}, arg[6:0]};
	assign skipPc  = 22'(pc + (c.longNext ? 22'd3 : 22'd2));

	// io byte tested by the io bit skips
	logic [15:0] ioAddr;
	logic [7:0]  ioByte;
	assign ioAddr = 16'(cis_pkg::IO_BASE + {11'h000, c.rr});
	assign ioByte = dmem[ioAddr[MAW-1:0]];

	cis_pkg::cis_alu_t alu;
	logic [7:0]        next_rdVal;
	logic              rdWe;
	logic              pairWe;
	logic              ptrWe;
	logic [4:0]        ptrIdx;
	logic [15:0]       ptrVal;
	logic [15:0]       next_ptr;
	logic [7:0]        flagMask;
	logic [21:0]       next_pc;
	logic              taken;
	logic [7:0]        next_status;

	always_comb
	begin
		alu = '0;
		next_rdVal = 8'h00;
		rdWe = 1'b0;
		pairWe = 1'b0;
		ptrWe = 1'b0;
		flagMask = 8'h00;
		next_pc = 22'(pc + 22'd1);
		taken = 1'b0;
		ptrIdx = 5'(cis_pkg::PTR_X_LOW + (c.rr[1] ? 4 : (c.rr[0] ? 2 : 0)));
		ptrVal = {rf[5'(ptrIdx + 5'd1)], rf[ptrIdx]};
		next_ptr = ptrVal;
		case (c.op)
			cis_pkg::OP_ADD:                       begin alu = add8(a, b, 1'b0); rdWe = 1'b1; flagMask = cis_pkg::MASK_ARITH; end
			cis_pkg::OP_ADD_CARRY:                 begin alu = add8(a, b, status[cis_pkg::FLAG_C]); rdWe = 1'b1; flagMask = cis_pkg::MASK_ARITH; end
			cis_pkg::OP_WORD_IMMEDIATE_SUM:        begin alu = word16(pairVal, c.imm[5:0], 1'b0); pairWe = 1'b1; flagMask = cis_pkg::MASK_WORD; end
			cis_pkg::OP_WORD_IMMEDIATE_DIFFERENCE: begin alu = word16(pairVal, c.imm[5:0], 1'b1); pairWe = 1'b1; flagMask = cis_pkg::MASK_WORD; end
			cis_pkg::OP_SUB:                       begin alu = sub8(a, b, 1'b0, 1'b1); rdWe = 1'b1; flagMask = cis_pkg::MASK_ARITH; end
			cis_pkg::OP_SUB_IMMEDIATE:             begin alu = sub8(a, c.imm, 1'b0, 1'b1); rdWe = 1'b1; flagMask = cis_pkg::MASK_ARITH; end
			cis_pkg::OP_SUB_BORROW:                begin alu = sub8(a, b, status[cis_pkg::FLAG_C], status[cis_pkg::FLAG_Z]); rdWe = 1'b1; flagMask = cis_pkg::MASK_ARITH; end
			cis_pkg::OP_IMMEDIATE_BORROW_SUBTRACT: begin alu = sub8(a, c.imm, status[cis_pkg::FLAG_C], status[cis_pkg::FLAG_Z]); rdWe = 1'b1; flagMask = cis_pkg::MASK_ARITH; end
			cis_pkg::OP_AND:                       begin alu = logic8(a & b); rdWe = 1'b1; flagMask = cis_pkg::MASK_LOGIC; end
			cis_pkg::OP_IMMEDIATE_CONJUNCTION:     begin alu = logic8(a & c.imm); rdWe = 1'b1; flagMask = cis_pkg::MASK_LOGIC; end
			cis_pkg::OP_OR:                        begin alu = logic8(a | b); rdWe = 1'b1; flagMask = cis_pkg::MASK_LOGIC; end
			cis_pkg::OP_IMMEDIATE_DISJUNCTION,
			cis_pkg::OP_SET_BITS:                  begin alu = logic8(a | c.imm); rdWe = 1'b1; flagMask = cis_pkg::MASK_LOGIC; end
			cis_pkg::OP_CLEAR_BITS:                begin alu = logic8(a & (8'hff - c.imm)); rdWe = 1'b1; flagMask = cis_pkg::MASK_LOGIC; end
			cis_pkg::OP_XOR:                       begin alu = logic8(a ^ b); rdWe = 1'b1; flagMask = cis_pkg::MASK_LOGIC; end
			cis_pkg::OP_ZERO_MINUS_TEST:           begin alu = logic8(a & a); rdWe = 1'b1; flagMask = cis_pkg::MASK_LOGIC; end
			cis_pkg::OP_CLEAR_REG:                 begin alu = logic8(a ^ a); rdWe = 1'b1; flagMask = cis_pkg::MASK_LOGIC; end
			cis_pkg::OP_ONES_COMPLEMENT:
			begin
				alu = logic8(8'hff - a);
				alu.flags[cis_pkg::FLAG_C] = 1'b1;
				rdWe = 1'b1;
				flagMask = cis_pkg::MASK_WORD;
			end
			cis_pkg::OP_TWOS_COMPLEMENT:           begin alu = sub8(8'h00, a, 1'b0, 1'b1); rdWe = 1'b1; flagMask = cis_pkg::MASK_ARITH; end
			cis_pkg::OP_INCREMENT:
			begin
				alu = logic8(8'(a + 8'h01));
				alu.flags[cis_pkg::FLAG_V] = (a == 8'h7f);
				alu.flags[cis_pkg::FLAG_S] = alu.flags[cis_pkg::FLAG_N] ^ (a == 8'h7f);
				rdWe = 1'b1;
				flagMask = cis_pkg::MASK_LOGIC;
			end
			cis_pkg::OP_DECREMENT:
			begin
				alu = logic8(8'(a - 8'h01));
				alu.flags[cis_pkg::FLAG_V] = (a == 8'h80);
				alu.flags[cis_pkg::FLAG_S] = alu.flags[cis_pkg::FLAG_N] ^ (a == 8'h80);
				rdWe = 1'b1;
				flagMask = cis_pkg::MASK_LOGIC;
			end
			cis_pkg::OP_SET_REG:                   begin alu = logic8(8'hff); rdWe = 1'b1; end
			cis_pkg::OP_RELATIVE_JUMP,
			cis_pkg::OP_RELATIVE_CALL:             begin next_pc = 22'(pc + relOff + 22'd1); taken = 1'b1; end
			cis_pkg::OP_POINTER_JUMP,
			cis_pkg::OP_POINTER_CALL:              begin next_pc = {6'h00, ptrZ}; taken = 1'b1; end
			cis_pkg::OP_EQUAL_SKIP:                begin taken = (a == b); end
			cis_pkg::OP_COMPARE:                   begin alu = sub8(a, b, 1'b0, 1'b1); flagMask = cis_pkg::MASK_ARITH; end
			cis_pkg::OP_COMPARE_CARRY:             begin alu = sub8(a, b, status[cis_pkg::FLAG_C], status[cis_pkg::FLAG_Z]); flagMask = cis_pkg::MASK_ARITH; end
			cis_pkg::OP_IMMEDIATE_COMPARE:         begin alu = sub8(a, c.imm, 1'b0, 1'b1); flagMask = cis_pkg::MASK_ARITH; end
			cis_pkg::OP_REG_BIT_CLEAR_SKIP:        begin taken = ~b[c.bitSel]; end
			cis_pkg::OP_REG_BIT_SET_SKIP:          begin taken = b[c.bitSel]; end
			cis_pkg::OP_IO_BIT_CLEAR_SKIP:         begin taken = ~ioByte[c.bitSel]; end
			cis_pkg::OP_IO_BIT_SET_SKIP:           begin taken = ioByte[c.bitSel]; end
			cis_pkg::OP_STATUS_BIT_BRANCH:         begin taken = status[c.bitSel]; end
			cis_pkg::OP_STATUS_BIT_CLEAR_BRANCH:   begin taken = ~status[c.bitSel]; end
			cis_pkg::OP_SIGNED_GE_BRANCH:          begin taken = ~(status[cis_pkg::FLAG_N] ^ status[cis_pkg::FLAG_V]); end
			cis_pkg::OP_SIGNED_LT_BRANCH:          begin taken = status[cis_pkg::FLAG_N] ^ status[cis_pkg::FLAG_V]; end
			cis_pkg::OP_UNSIGNED_GE_BRANCH:        begin taken = ~status[cis_pkg::FLAG_C]; end
			cis_pkg::OP_UNSIGNED_LT_BRANCH:        begin taken = status[cis_pkg::FLAG_C]; end
			cis_pkg::OP_IRQ_ON_BRANCH:             begin taken = status[cis_pkg::FLAG_I]; end
			cis_pkg::OP_IRQ_OFF_BRANCH:            begin taken = ~status[cis_pkg::FLAG_I]; end
			cis_pkg::OP_DIRECT_LOAD:               begin next_rdVal = memRead(arg); rdWe = 1'b1; next_pc = 22'(pc + 22'd2); end
			cis_pkg::OP_PTR_LOAD:                  begin next_rdVal = memRead(ptrVal); rdWe = 1'b1; end
			cis_pkg::OP_PTR_LOAD_INC:
			begin
				next_rdVal = memRead(ptrVal);
				rdWe = 1'b1;
				next_ptr = 16'(ptrVal + 16'h0001);
				ptrWe = 1'b1;
			end
			cis_pkg::OP_PTR_LOAD_DEC:
			begin
				next_ptr = 16'(ptrVal - 16'h0001);
				next_rdVal = memRead(next_ptr);
				rdWe = 1'b1;
				ptrWe = 1'b1;
			end
			cis_pkg::OP_DISPLACED_LOAD:            begin next_rdVal = memRead(16'(ptrVal + {10'h000, arg[5:0]})); rdWe = 1'b1; end
			default:                               begin next_pc = pc; end
		endcase
		if (c.op inside {cis_pkg::OP_EQUAL_SKIP, cis_pkg::OP_REG_BIT_CLEAR_SKIP,
			cis_pkg::OP_REG_BIT_SET_SKIP, cis_pkg::OP_IO_BIT_CLEAR_SKIP,
			cis_pkg::OP_IO_BIT_SET_SKIP})
			next_pc = taken ? skipPc : 22'(pc + 22'd1);
		else if (c.op >= cis_pkg::OP_STATUS_BIT_BRANCH && c.op <= cis_pkg::OP_IRQ_OFF_BRANCH)
			next_pc = taken ? 22'(pc + brOff + 22'd1) : 22'(pc + 22'd1);
		if (rdWe && c.op < cis_pkg::OP_RELATIVE_JUMP)
			next_rdVal = alu.res[7:0];
		next_status = (status & ~flagMask) | (alu.flags & flagMask);
	end

	// general registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			for (int i = 0; i < cis_pkg::REGS; i++)
				rf[i] <= 8'h00;
		else
		begin
			if (wrEdge && wbAdr == cis_pkg::ADDR_RFDATA && wbSel[0])
				rf[rfSel] <= wbDatIn[7:0];
			if (exec && rdWe)
				rf[c.rd] <= next_rdVal;
			if (exec && pairWe)
			begin
				rf[rdE] <= alu.res[7:0];
				rf[5'(rdE | 5'd1)] <= alu.res[15:8];
			end
			// pointer update lands on the same edge as the loaded byte and overrides it
			if (exec && ptrWe)
			begin
				rf[ptrIdx] <= next_ptr[7:0];
				rf[5'(ptrIdx + 5'd1)] <= next_ptr[15:8];
			end
		end
	end

	// data space, software access only
	always_ff @(posedge clk)
	begin
		if (wrEdge && wbAdr == cis_pkg::ADDR_MDATA && wbSel[0])
			dmem[memSel[MAW-1:0]] <= wbDatIn[7:0];
	end

	// program counter and status
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pc <= cis_pkg::PC_RESET;
			status <= cis_pkg::STATUS_RESET;
		end
		else if (exec)
		begin
			pc <= next_pc;
			status <= next_status;
		end
		else if (wrEdge && wbAdr == cis_pkg::ADDR_PC)
			pc <= pcMerged[21:0];
		else if (wrEdge && wbAdr == cis_pkg::ADDR_STATUS && wbSel[0])
			status <= wbDatIn[7:0];
	end

	// command, argument and selectors
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cmd <= cis_pkg::cis_cmd_t'(cis_pkg::CMD_RESET);
			arg <= 16'h0000;
			rfSel <= 5'h00;
			memSel <= 16'h0000;
			lastResult <= 16'h0000;
			lastTaken <= 1'b0;
		end
		else if (wrEdge)
		begin
			if (exec)
			begin
				cmd <= byteMerge(cis_pkg::CMD_RESET, wbDatIn, wbSel);
				lastResult <= pairWe ? alu.res : (rdWe ? {8'h00, next_rdVal} : alu.res);
				lastTaken <= taken;
			end
			if (wbAdr == cis_pkg::ADDR_ARG)
				arg <= argMerged[15:0];
			if (wbAdr == cis_pkg::ADDR_RFSEL && wbSel[0])
				rfSel <= wbDatIn[4:0];
			if (wbAdr == cis_pkg::ADDR_MSEL)
				memSel <= selMerged[15:0];
		end
	end

	// one-wait-state answer, data registered with ack
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wbAck <= 1'b0;
			wbDatOut <= 32'h00000000;
		end
		else
		begin
			wbAck <= access & ~wbAck;
			if (access && !wbAck && !wbWe)
				case (wbAdr)
					cis_pkg::ADDR_CMD:    wbDatOut <= cmd;
					cis_pkg::ADDR_ARG:    wbDatOut <= {16'h0000, arg};
					cis_pkg::ADDR_PC:     wbDatOut <= {10'h000, pc};
					cis_pkg::ADDR_STATUS: wbDatOut <= {24'h000000, status};
					cis_pkg::ADDR_RFSEL:  wbDatOut <= {27'h0000000, rfSel};
					cis_pkg::ADDR_RFDATA: wbDatOut <= {24'h000000, rf[rfSel]};
					cis_pkg::ADDR_MSEL:   wbDatOut <= {16'h0000, memSel};
					cis_pkg::ADDR_MDATA:  wbDatOut <= {24'h000000, memRead(memSel)};
					cis_pkg::ADDR_RESULT: wbDatOut <= {15'h0000, lastTaken, lastResult};
					default:              wbDatOut <= 32'h00000000;
				endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence reqStart;
		access && !wbAck;
	endsequence
	sequence execOf(cis_pkg::cis_op_t o);
		exec && c.op == o;
	endsequence

	bus_ack_pulse_a: assert property (reqStart |=> wbAck ##1 !wbAck) else $error("ack not one pulse");
	word_sum_half_a: assert property (execOf(cis_pkg::OP_WORD_IMMEDIATE_SUM) |=> status[cis_pkg::FLAG_H] == $past(status[cis_pkg::FLAG_H])) else $error("word sum touched H");
	borrow_sub_a: assert property (execOf(cis_pkg::OP_IMMEDIATE_BORROW_SUBTRACT) && a == c.imm && status[cis_pkg::FLAG_C] |=> status[cis_pkg::FLAG_C] && status[cis_pkg::FLAG_N] && !status[cis_pkg::FLAG_Z]) else $error("borrow lost");
	and_keep_carry_a: assert property (execOf(cis_pkg::OP_IMMEDIATE_CONJUNCTION) |=> status[cis_pkg::FLAG_C] == $past(status[cis_pkg::FLAG_C]) && !status[cis_pkg::FLAG_V]) else $error("and changed C or V");
	rel_jump_a: assert property (execOf(cis_pkg::OP_RELATIVE_JUMP) |=> pc == 22'($past(pc) + $past(relOff) + 22'd1)) else $error("relative jump target wrong");
	ptr_jump_a: assert property (execOf(cis_pkg::OP_POINTER_JUMP) |=> pc == {6'h00, $past(ptrZ)}) else $error("pointer jump target wrong");
	equal_skip_a: assert property (execOf(cis_pkg::OP_EQUAL_SKIP) && a == b && !c.longNext |=> pc == 22'($past(pc) + 22'd2) ##1 wbAck == 1'b0) else $error("equal skip wrong");
	compare_flags_a: assert property (execOf(cis_pkg::OP_COMPARE) && a == b |=> status[cis_pkg::FLAG_Z] && !status[cis_pkg::FLAG_C]) else $error("compare flags wrong");
	signed_ge_a: assert property (execOf(cis_pkg::OP_SIGNED_GE_BRANCH) && status[cis_pkg::FLAG_N] != status[cis_pkg::FLAG_V] |=> pc == 22'($past(pc) + 22'd1)) else $error("signed branch taken wrongly");
	post_inc_a: assert property (execOf(cis_pkg::OP_PTR_LOAD_INC) && c.rr[1:0] == 2'd0 && c.rd < 5'd26 |=> {rf[27], rf[26]} == 16'($past(ptrVal) + 16'h0001)) else $error("pointer not incremented");

endmodule // cis_exec

/* bench/cis_exec_test.sv */
// self-checking bench of the instruction execution unit
`timescale 1ns/1ns
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin miscompares++; \
	$display("BAD %0t got %h want %h", $time, (a), (e)); end end
module cis_exec_test;
	logic        clk = 0, rst_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck;
	logic [7:0]  wbAdr = 8'h00;
	logic [31:0] wbDatIn = 32'h0, wbDatOut, q, p;
	int          miscompares = 0, numChecks = 0;
	always #20 clk = ~clk;
	cis_exec u_cis_exec (.clk(clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbAdr(wbAdr), .wbSel(4'hf), .wbDatIn(wbDatIn), .wbAck(wbAck), .wbDatOut(wbDatOut));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one classic cycle; ack and read data taken at the same rising edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbDatIn} <= {2'b11, w, a, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wbAck !== 1'b1 && n < 8);
		if (wbAck !== 1'b1)
		begin
			miscompares++;
			end_sim;
		end
		q = wbDatOut;
		{wbCyc, wbStb, wbWe} <= 3'b000;
	endtask
	task automatic setr(input logic [4:0] i, input logic [7:0] v);
		bus(cis_pkg::ADDR_RFSEL, 1'b1, {27'h0, i});
		bus(cis_pkg::ADDR_RFDATA, 1'b1, {24'h0, v});
	endtask
	task automatic getr(input logic [4:0] i);
		bus(cis_pkg::ADDR_RFSEL, 1'b1, {27'h0, i});
		bus(cis_pkg::ADDR_RFDATA, 1'b0, 32'h0);
	endtask
	task automatic ex(input cis_pkg::cis_op_t o, input logic [4:0] d, r, input logic [7:0] k,
		input logic l);
		bus(cis_pkg::ADDR_PC, 1'b0, 32'h0);
		p = q;
		bus(cis_pkg::ADDR_CMD, 1'b1, {4'h0, l, 3'h0, k, r, d, o});
	endtask
	task automatic flags(input logic [7:0] e);
		bus(cis_pkg::ADDR_STATUS, 1'b0, 32'h0);
		`CHK(q[7:0], e)
	endtask
	task automatic pcis(input logic [21:0] d);
		bus(cis_pkg::ADDR_PC, 1'b0, 32'h0);
		`CHK(q[21:0], 22'(p[21:0] + d))
	endtask
	task automatic t_misc;
		setr(5'd5, 8'h7f);
		setr(5'd6, 8'h01);
		bus(cis_pkg::ADDR_STATUS, 1'b1, 32'h01);
		ex(cis_pkg::OP_ADD_CARRY, 5'd5, 5'd6, 8'h00, 1'b0);
		flags(8'h2c);
		getr(5'd5);
		`CHK(q[7:0], 8'h81)
		bus(cis_pkg::ADDR_STATUS, 1'b1, 32'h01);
		ex(cis_pkg::OP_DECREMENT, 5'd6, 5'd0, 8'h00, 1'b0);
		flags(8'h03);
		ex(cis_pkg::OP_ONES_COMPLEMENT, 5'd6, 5'd0, 8'h00, 1'b0);
		flags(8'h15);
		ex(cis_pkg::OP_TWOS_COMPLEMENT, 5'd6, 5'd0, 8'h00, 1'b0);
		flags(8'h21);
		bus(cis_pkg::ADDR_RESULT, 1'b0, 32'h0);
		`CHK(q, 32'h00000001)
		ex(cis_pkg::OP_SET_REG, 5'd6, 5'd0, 8'h00, 1'b0);
		flags(8'h21);
		getr(5'd6);
		`CHK(q[7:0], 8'hff)
	endtask
	task automatic t_arith;
		bus(cis_pkg::ADDR_STATUS, 1'b1, 32'h20);
		setr(5'd24, 8'hff);
		setr(5'd25, 8'hff);
		ex(cis_pkg::OP_WORD_IMMEDIATE_SUM, 5'd24, 5'd0, 8'h01, 1'b0);
		flags(8'h23);
		ex(cis_pkg::OP_WORD_IMMEDIATE_DIFFERENCE, 5'd24, 5'd0, 8'h01, 1'b0);
		flags(8'h35);
		getr(5'd25);
		`CHK(q[7:0], 8'hff)
		bus(cis_pkg::ADDR_STATUS, 1'b1, 32'h01);
		setr(5'd16, 8'h10);
		ex(cis_pkg::OP_IMMEDIATE_BORROW_SUBTRACT, 5'd16, 5'd0, 8'h00, 1'b0);
		flags(8'h20);
		ex(cis_pkg::OP_IMMEDIATE_COMPARE, 5'd16, 5'd0, 8'h0f, 1'b0);
		flags(8'h02);
		getr(5'd16);
		`CHK(q[7:0], 8'h0f)
	endtask
	task automatic t_logic;
		bus(cis_pkg::ADDR_STATUS, 1'b1, 32'h21);
		ex(cis_pkg::OP_IMMEDIATE_CONJUNCTION, 5'd16, 5'd0, 8'hf0, 1'b0);
		flags(8'h23);
		ex(cis_pkg::OP_SET_BITS, 5'd16, 5'd0, 8'h80, 1'b0);
		flags(8'h35);
		bus(cis_pkg::ADDR_STATUS, 1'b1, 32'h21);
		ex(cis_pkg::OP_ZERO_MINUS_TEST, 5'd16, 5'd0, 8'h00, 1'b0);
		flags(8'h35);
		ex(cis_pkg::OP_CLEAR_BITS, 5'd16, 5'd0, 8'h80, 1'b0);
		flags(8'h23);
	endtask
	task automatic t_flow;
		cis_pkg::cis_op_t o[8] = '{cis_pkg::OP_SIGNED_GE_BRANCH, cis_pkg::OP_SIGNED_LT_BRANCH,
			cis_pkg::OP_UNSIGNED_GE_BRANCH, cis_pkg::OP_UNSIGNED_LT_BRANCH,
			cis_pkg::OP_IRQ_ON_BRANCH, cis_pkg::OP_IRQ_OFF_BRANCH,
			cis_pkg::OP_STATUS_BIT_BRANCH, cis_pkg::OP_STATUS_BIT_CLEAR_BRANCH};
		logic [7:0] s[8] = '{8'h0c, 8'h0c, 8'h00, 8'h00, 8'h80, 8'h80, 8'h01, 8'h01};
		bus(cis_pkg::ADDR_ARG, 1'b1, 32'h3);
		for (int i = 0; i < 8; i++)
		begin
			bus(cis_pkg::ADDR_STATUS, 1'b1, {24'h0, s[i]});
			ex(o[i], 5'd0, 5'd0, 8'h00, 1'b0);
			bus(cis_pkg::ADDR_PC, 1'b0, 32'h0);
			`CHK(q[21:0], p[21:0] + ((i % 2) ? 22'd1 : 22'd4))
		end
		bus(cis_pkg::ADDR_MSEL, 1'b1, 32'h20);
		bus(cis_pkg::ADDR_MDATA, 1'b1, 32'h01);
		ex(cis_pkg::OP_IO_BIT_SET_SKIP, 5'd0, 5'd0, 8'h00, 1'b0);
		pcis(22'd2);
		ex(cis_pkg::OP_IO_BIT_CLEAR_SKIP, 5'd0, 5'd0, 8'h00, 1'b0);
		pcis(22'd1);
		setr(5'd16, 8'h02);
		ex(cis_pkg::OP_REG_BIT_CLEAR_SKIP, 5'd0, 5'd16, 8'h00, 1'b1);
		pcis(22'd3);
		ex(cis_pkg::OP_REG_BIT_SET_SKIP, 5'd0, 5'd16, 8'h00, 1'b0);
		pcis(22'd1);
		bus(cis_pkg::ADDR_ARG, 1'b1, 32'hffd);
		ex(cis_pkg::OP_RELATIVE_JUMP, 5'd0, 5'd0, 8'h00, 1'b0);
		bus(cis_pkg::ADDR_PC, 1'b0, 32'h0);
		`CHK(q[21:0], p[21:0] - 22'd2)
		setr(5'd30, 8'hef);
		setr(5'd31, 8'hbe);
		ex(cis_pkg::OP_POINTER_JUMP, 5'd0, 5'd0, 8'h00, 1'b0);
		bus(cis_pkg::ADDR_PC, 1'b0, 32'h0);
		`CHK(q[21:0], 22'h00beef)
		ex(cis_pkg::OP_EQUAL_SKIP, 5'd24, 5'd25, 8'h00, 1'b1);
		bus(cis_pkg::ADDR_PC, 1'b0, 32'h0);
		`CHK(q[21:0], 22'h00bef2)
	endtask
	task automatic t_load;
		bus(cis_pkg::ADDR_MSEL, 1'b1, 32'h40);
		bus(cis_pkg::ADDR_MDATA, 1'b1, 32'ha5);
		setr(5'd26, 8'h40);
		ex(cis_pkg::OP_PTR_LOAD_INC, 5'd1, 5'd0, 8'h00, 1'b0);
		getr(5'd26);
		`CHK(q[7:0], 8'h41)
		ex(cis_pkg::OP_PTR_LOAD_DEC, 5'd2, 5'd0, 8'h00, 1'b0);
		getr(5'd2);
		`CHK(q[7:0], 8'ha5)
		bus(cis_pkg::ADDR_ARG, 1'b1, 32'h40);
		ex(cis_pkg::OP_DIRECT_LOAD, 5'd3, 5'd0, 8'h00, 1'b0);
		getr(5'd3);
		`CHK(q[7:0], 8'ha5)
		setr(5'd28, 8'h3e);
		bus(cis_pkg::ADDR_ARG, 1'b1, 32'h2);
		ex(cis_pkg::OP_DISPLACED_LOAD, 5'd4, 5'd1, 8'h00, 1'b0);
		getr(5'd4);
		`CHK(q[7:0], 8'ha5)
		getr(5'd28);
		`CHK(q[7:0], 8'h3e)
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		bus(cis_pkg::ADDR_CMD, 1'b0, 32'h0);
		`CHK(q, 32'h0000003f)
		bus(8'h30, 1'b0, 32'h0);
		`CHK(q, 32'h0)
		t_arith;
		t_logic;
		t_misc;
		t_flow;
		t_load;
		end_sim;
	end
endmodule // cis_exec_test
